// File: design/urxsf_pkg.sv
package urxsf_pkg;

  // Error triple of one buffer: [2] marker, [1] parity, [0] overrun.
  typedef logic [2:0] urxsf_err_t;

  typedef struct packed {
    logic [7:0] data;
    logic       parity;
    logic       stop;
    logic       marker;
  } urxsf_frame_t;

  typedef struct packed {
    logic                  ferr;
    urxsf_err_t [3:0]      berr;
    logic                  rxie;
    logic                  rxirq;
    logic                  txie;
    logic                  txirq;
    logic [1:0]            cnt;
    logic [7:0]            ctl;
    logic [3:0][7:0]       rbuf;
    logic [3:0]            unread;
    logic [7:0]            rdata;
  } urxsf_state_t;

endpackage : urxsf_pkg

// File: design/urxsf_regs.svh
`ifndef URXSF_REGS_SVH
`define URXSF_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------------
`define URXSF_OFS_PRIM   5'h00
`define URXSF_OFS_SEC    5'h04
`define URXSF_OFS_THR    5'h08
`define URXSF_OFS_CTL    5'h0c
`define URXSF_OFS_BUF0   5'h10
`define URXSF_OFS_BUF1   5'h14
`define URXSF_OFS_BUF2   5'h18
`define URXSF_OFS_BUF3   5'h1c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define URXSF_B_FERR     0
`define URXSF_B_ERRLO    1
`define URXSF_B_RXIE     4
`define URXSF_B_RXIRQ    5
`define URXSF_B_TXIE     6
`define URXSF_B_TXIRQ    7
`define URXSF_B_ERRHI    5
`define URXSF_B_CNT      4
`define URXSF_B_MD       0
`define URXSF_B_MPC      2
`define URXSF_B_EXP      3
`define URXSF_B_PEN      5
`define URXSF_B_EVN      6
`define URXSF_B_REN      7

// ----------------------------------------------------------------------------
// Reset values, fixed-one mask and unmapped read value
// ----------------------------------------------------------------------------
`define URXSF_PRIM_RST   8'h00
`define URXSF_SEC_RST    8'h11
`define URXSF_THR_RST    8'hc1
`define URXSF_CTL_RST    8'h12
`define URXSF_CTL_ONES   8'h12
`define URXSF_UNMAP_RD   8'h00

`endif

// File: design/urxsf_top.sv
`include "urxsf_regs.svh"

module urxsf_top #(
  parameter int ADDR_W  = 5,
  parameter int NUM_BUF = 4
) (
  // Clock, reset, enable
  input  wire logic                  CLOCK_IN,
  input  wire logic                  RST_IN,
  input  wire logic                  CE_IN,
  // Register port
  input  wire logic [ADDR_W-1:0]     ADDR_IN,
  input  wire logic [7:0]            WR_DATA_IN,
  input  wire logic                  WR_IN,
  input  wire logic                  RD_IN,
  output logic      [7:0]            RD_DATA_OUT,
  // Receive shifter and transmitter events
  input  wire logic                  RX_DONE_IN,
  input  wire urxsf_pkg::urxsf_frame_t RX_FRAME_IN,
  input  wire logic                  TX_READY_IN,
  // Interrupt requests
  output logic                       RX_IRQ_OUT,
  output logic                       TX_IRQ_OUT
);

  // --------------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------------
  if (NUM_BUF != 4) begin : g_bad_buf
    $error("urxsf_top supports exactly four receive buffers");
  end
  if (ADDR_W < 5) begin : g_bad_addr
    $error("urxsf_top needs at least five address bits");
  end

  localparam urxsf_pkg::urxsf_state_t ST_RST = '{ctl: `URXSF_CTL_RST, default: '0};

  urxsf_pkg::urxsf_state_t state_q;
  urxsf_pkg::urxsf_state_t state_d;

  // --------------------------------------------------------------------------
  // Frame decode
  // --------------------------------------------------------------------------
  logic       md_mp;
  logic       acc_addr;
  logic       ring;
  logic       take;
  logic       par_bad;
  logic       mrk_bad;
  logic [1:0] tgt;
  logic [4:0] rofs;

  assign md_mp    = state_q.ctl[`URXSF_B_MD];
  assign acc_addr = state_q.ctl[`URXSF_B_MPC];
  assign ring     = state_q.ctl[`URXSF_B_EXP];
  // Address-only acceptance drops data frames without any store or request.
  assign take     = CE_IN && RX_DONE_IN && state_q.ctl[`URXSF_B_REN]
                    && !(md_mp && acc_addr && !RX_FRAME_IN.marker);
  assign par_bad  = state_q.ctl[`URXSF_B_PEN]
                    && ((^RX_FRAME_IN.data ^ RX_FRAME_IN.parity)
                        != !state_q.ctl[`URXSF_B_EVN]);
  assign mrk_bad  = md_mp && !acc_addr && RX_FRAME_IN.marker;
  assign tgt      = ring ? state_q.cnt : 2'h0;
  assign rofs     = ADDR_IN[4:0];

  // --------------------------------------------------------------------------
  // Register views
  // --------------------------------------------------------------------------
  logic [7:0] prim_v;
  logic [7:0] sec_v;
  logic [7:0] thr_v;

  assign prim_v = {state_q.txirq, state_q.txie, state_q.rxirq, state_q.rxie,
                   state_q.berr[0], state_q.ferr};
  assign sec_v  = {state_q.berr[2], 1'b1, state_q.berr[1], 1'b1};
  // Third word layout, counter view, fixed ones.
  assign thr_v  = {2'b11, state_q.cnt, state_q.berr[3], 1'b1};

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    if (CE_IN) begin
      if (RD_IN) begin
        case (rofs)
          `URXSF_OFS_PRIM: state_d.rdata = prim_v;
          `URXSF_OFS_SEC:  state_d.rdata = sec_v;
          `URXSF_OFS_THR:  state_d.rdata = thr_v;
          `URXSF_OFS_CTL:  state_d.rdata = state_q.ctl;
          `URXSF_OFS_BUF0, `URXSF_OFS_BUF1, `URXSF_OFS_BUF2, `URXSF_OFS_BUF3: begin
            state_d.rdata               = state_q.rbuf[rofs[3:2]];
            state_d.unread[rofs[3:2]]   = 1'b0;
          end
          default:         state_d.rdata = `URXSF_UNMAP_RD;
        endcase
      end
      if (WR_IN) begin
        case (rofs)
          `URXSF_OFS_PRIM: begin
            state_d.ferr    = WR_DATA_IN[`URXSF_B_FERR];
            state_d.berr[0] = WR_DATA_IN[`URXSF_B_ERRLO +: 3];
            state_d.rxie    = WR_DATA_IN[`URXSF_B_RXIE];
            state_d.rxirq   = WR_DATA_IN[`URXSF_B_RXIRQ];
            state_d.txie    = WR_DATA_IN[`URXSF_B_TXIE];
            state_d.txirq   = WR_DATA_IN[`URXSF_B_TXIRQ];
          end
          `URXSF_OFS_SEC: begin
            state_d.berr[1] = WR_DATA_IN[`URXSF_B_ERRLO +: 3];
            state_d.berr[2] = WR_DATA_IN[`URXSF_B_ERRHI +: 3];
          end
          `URXSF_OFS_THR:  state_d.berr[3] = WR_DATA_IN[`URXSF_B_ERRLO +: 3];
          `URXSF_OFS_CTL:  state_d.ctl     = WR_DATA_IN | `URXSF_CTL_ONES;
          default: begin
          end
        endcase
      end
      // Events are applied after writes, so a set in the clearing cycle wins.
      if (take) begin
        // Overrun on unread, byte still loaded.
        for (int i = 0; i < 4; i++) begin
          if (tgt == i[1:0]) begin
            state_d.berr[i] = state_d.berr[i]
                              | {mrk_bad, par_bad, state_q.unread[i]};
            state_d.rbuf[i]   = RX_FRAME_IN.data;
            state_d.unread[i] = 1'b1;
          end
        end
        if (!RX_FRAME_IN.stop) begin
          state_d.ferr = 1'b1;
        end
        state_d.rxirq = 1'b1;
        if (ring) begin
          state_d.cnt = state_q.cnt + 2'h1;
        end
      end
      if (TX_READY_IN) begin
        state_d.txirq = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // Reset values of all status words.
  always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_q <= ST_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign RD_DATA_OUT = state_q.rdata;
  assign RX_IRQ_OUT  = state_q.rxirq && state_q.rxie;
  assign TX_IRQ_OUT  = state_q.txirq && state_q.txie;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic wr_prim;
  logic wr_sec;
  logic wr_thr;
  assign wr_prim = CE_IN && WR_IN && (rofs == `URXSF_OFS_PRIM);
  assign wr_sec  = CE_IN && WR_IN && (rofs == `URXSF_OFS_SEC);
  assign wr_thr  = CE_IN && WR_IN && (rofs == `URXSF_OFS_THR);

  sequence s_take_to(logic [1:0] b);
    take && (tgt == b);
  endsequence

  property p_err_set(logic [1:0] b, logic cause, int k);
    @(posedge CLOCK_IN) disable iff (RST_IN)
      s_take_to(b) ##0 cause |=> state_q.berr[b][k];
  endproperty

  chk_framing_set: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      take && !RX_FRAME_IN.stop |=> state_q.ferr && prim_v[0])
    else $error("framing flag not set");

  chk_overrun_first: assert property (p_err_set(2'h0, state_q.unread[0], 0))
    else $error("first buffer overrun not set");

  chk_overrun_second: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      s_take_to(2'h1) ##0 state_q.unread[1]
      |=> sec_v[1] && state_q.rbuf[1] == $past(RX_FRAME_IN.data))
    else $error("second buffer overrun or load wrong");

  chk_parity_flag: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      take && par_bad |=> state_q.berr[$past(tgt)][1])
    else $error("parity error not flagged");

  chk_marker_flag: assert property (p_err_set(2'h3, mrk_bad, 2))
    else $error("marker error not flagged");

  chk_rx_gate: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      take && state_q.rxie && !wr_prim |=> RX_IRQ_OUT)
    else $error("receive request not forwarded");

  chk_rx_hold: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      state_q.rxirq && !wr_prim |=> state_q.rxirq)
    else $error("receive flag dropped");

  chk_tx_hold: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      CE_IN && TX_READY_IN ##1 !wr_prim [*3] |-> state_q.txirq)
    else $error("transmit flag dropped");

  chk_tx_gate: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      !state_q.txie |-> !TX_IRQ_OUT)
    else $error("transmit request leaked");

  chk_sticky_errs: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      sec_v[7] && !wr_sec |=> sec_v[7])
    else $error("error flag cleared by hardware");

  chk_cnt_wrap: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      take && ring |=> state_q.cnt == 2'($past(state_q.cnt) + 2'h1))
    else $error("buffer counter did not advance");

  chk_cnt_ro: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      wr_thr && !take |=> $stable(state_q.cnt))
    else $error("counter changed by write");

  chk_fixed_ones: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      CE_IN && RD_IN && rofs == `URXSF_OFS_THR |=> RD_DATA_OUT[7:6] == 2'b11
      && RD_DATA_OUT[0])
    else $error("unimplemented bits not read as one");

  chk_single_mode: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      take && !ring |=> state_q.unread[0] && $stable(state_q.rbuf[1]))
    else $error("single mode stored outside first buffer");

  // --------------------------------------------------------------------------
  // Further checks
  // --------------------------------------------------------------------------
  // Reset is checked without a disable, since the reset values are what it guards.
  chk_reset_words: assert property (
    @(posedge CLOCK_IN)
      RST_IN |-> prim_v == `URXSF_PRIM_RST && sec_v == `URXSF_SEC_RST && thr_v == `URXSF_THR_RST)
    else $error("status words not at reset values");

  chk_ferr_sticky: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      state_q.ferr && !wr_prim |=> state_q.ferr)
    else $error("framing flag cleared by hardware");

  chk_first_sticky: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      state_q.berr[0] != 3'h0 && !wr_prim
      |=> (state_q.berr[0] & $past(state_q.berr[0])) == $past(state_q.berr[0]))
    else $error("first buffer error flag cleared by hardware");

  chk_fourth_sticky: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      state_q.berr[3] != 3'h0 && !wr_thr
      |=> (state_q.berr[3] & $past(state_q.berr[3])) == $past(state_q.berr[3]))
    else $error("fourth buffer error flag cleared by hardware");

  chk_rx_set: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      take |=> state_q.rxirq)
    else $error("receive flag not set");

  chk_tx_set: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      CE_IN && TX_READY_IN |=> state_q.txirq)
    else $error("transmit flag not set");

  chk_rx_mask: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      !state_q.rxie |-> !RX_IRQ_OUT)
    else $error("receive request leaked");

  chk_third_overrun: assert property (p_err_set(2'h2, state_q.unread[2], 0))
    else $error("third buffer overrun not set");

  chk_fourth_overrun: assert property (p_err_set(2'h3, state_q.unread[3], 0))
    else $error("fourth buffer overrun not set");

  chk_second_parity: assert property (p_err_set(2'h1, par_bad, 1))
    else $error("second buffer parity error not flagged");

  chk_ring_wrap: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      take && ring && tgt == 2'h3 |=> state_q.cnt == 2'h0 && state_q.unread[3])
    else $error("ring did not wrap after fourth buffer");

  // Ignored address-mode data frames must leave buffers and counter alone.
  chk_addr_drop: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      CE_IN && RX_DONE_IN && md_mp && acc_addr && !RX_FRAME_IN.marker
      |=> $stable(state_q.rbuf) && $stable(state_q.cnt))
    else $error("ignored frame changed buffers");

  chk_shared_frame: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      take && ring && !RX_FRAME_IN.stop |=> prim_v[0])
    else $error("shared framing flag not set in ring mode");

  chk_read_clears: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      CE_IN && RD_IN && rofs == `URXSF_OFS_BUF1 && !take |=> !state_q.unread[1])
    else $error("buffer read not recorded");

  chk_single_cnt: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      take && !ring |=> $stable(state_q.cnt))
    else $error("counter moved in single mode");

  // The enable gates every strobe and event, so a frozen cycle leaves all state alone.
  chk_ce_freeze: assert property (
    @(posedge CLOCK_IN) disable iff (RST_IN)
      !CE_IN |=> state_q == $past(state_q))
    else $error("state changed while clock enable low");

endmodule : urxsf_top

// File: verif/uart_rx_status_flags_tb.sv
module uart_rx_status_flags_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [7:0] d;
    logic [1:0] i;
  } urxsf_exp_t;

  logic                    clk, rst, we, re, done, txr, rd_pend, ce;
  logic [4:0]              addr;
  logic [7:0]              wdata, rdata, dat;
  logic                    rx_irq, tx_irq;
  urxsf_pkg::urxsf_frame_t frm;
  urxsf_exp_t              q[$];
  urxsf_exp_t              e;
  logic [31:0]             seed;
  logic [7:0]              bd[4];
  int                      fail_count, total_checks;

  urxsf_top i_urxsf_top (
    .CLOCK_IN(clk), .RST_IN(rst), .CE_IN(ce), .ADDR_IN(addr), .WR_DATA_IN(wdata),
    .WR_IN(we), .RD_IN(re), .RD_DATA_OUT(rdata), .RX_DONE_IN(done), .RX_FRAME_IN(frm),
    .TX_READY_IN(txr), .RX_IRQ_OUT(rx_irq), .TX_IRQ_OUT(tx_irq)
  );

  // ----------------------------------------------------------------------------
  // Drivers and checking
  // ----------------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    xs = v ^ (v << 5);
  endfunction : xs

  // Every input is set once per cycle, so back-to-back strobes never race.
  task automatic cyc(input logic w, r, input logic [4:0] a, input logic [7:0] d,
                     input logic x, input logic [10:0] f, input logic t);
    we <= w;
    re <= r;
    addr <= a;
    wdata <= d;
    done <= x;
    frm <= f;
    txr <= t;
    @(posedge clk);
  endtask : cyc

  task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] i);
    q.push_back('{d, i});
    cyc(1'b0, 1'b1, a, wdata, 1'b0, frm, 1'b0);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d, 1'b0, frm, 1'b0);
  endtask : wr

  // Odd parity is assumed; a set bad flag flips the parity bit.
  task automatic rxf(input logic bad, stp, mk);
    seed = xs(seed);
    dat = seed[7:0];
    cyc(1'b0, 1'b0, addr, wdata, 1'b1, {dat, (~^dat) ^ bad, stp, mk}, 1'b0);
  endtask : rxf

  task automatic tx();
    cyc(1'b0, 1'b0, addr, wdata, 1'b0, frm, 1'b1);
  endtask : tx

  task automatic clr();
    wr(5'h00, 8'h00);
    wr(5'h04, 8'h00);
    wr(5'h08, 8'h00);
  endtask : clr

  task automatic round();
    for (int k = 0; k < 4; k++) begin
      rxf(1'b0, 1'b1, 1'b0);
    end
  endtask : round

  task automatic chk(input string n, input logic [7:0] s, x);
    total_checks++;
    if (s !== x) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  always @(posedge clk) begin
    rd_pend <= re;
  end

  // Read data appear in the cycle after the strobe and hold until the next read, so they are taken mid-cycle.
  always @(negedge clk) begin
    if (rd_pend) begin
      e = q.pop_front();
      chk("read data", rdata, e.d);
      chk("irq lines", {6'h00, rx_irq, tx_irq}, {6'h00, e.i});
    end
  end

  // ----------------------------------------------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #400000;
    fail_count++;
    end_sim();
  end

  initial begin
    {we, re, done, txr, rd_pend} = '0;
    ce = 1'b1;
    addr = 5'h00;
    wdata = 8'h00;
    frm = '0;
    seed = 32'hc1cd152d;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(5'h00, 8'h00, 2'b00);
    rd(5'h04, 8'h11, 2'b00);
    rd(5'h08, 8'hc1, 2'b00);
    rd(5'h02, 8'h00, 2'b00);
    wr(5'h00, 8'h40);
    tx();
    rd(5'h00, 8'hc0, 2'b01);
    wr(5'h00, 8'h00);
    tx();
    rd(5'h00, 8'h80, 2'b00);
    wr(5'h0c, 8'ha0);
    wr(5'h00, 8'h10);
    rxf(1'b1, 1'b0, 1'b0);
    rd(5'h00, 8'h35, 2'b10);
    rxf(1'b0, 1'b1, 1'b0);
    rd(5'h00, 8'h37, 2'b10);
    rd(5'h10, dat, 2'b10);
    wr(5'h00, 8'h10);
    rxf(1'b0, 1'b1, 1'b0);
    rd(5'h00, 8'h30, 2'b10);
    rd(5'h08, 8'hc1, 2'b10);
    wr(5'h00, 8'h00);
    rxf(1'b0, 1'b1, 1'b0);
    rd(5'h00, 8'h22, 2'b00);
    rd(5'h10, dat, 2'b00);
    wr(5'h0c, 8'h81);
    wr(5'h00, 8'h00);
    rxf(1'b0, 1'b1, 1'b1);
    bd[0] = dat;
    rd(5'h00, 8'h28, 2'b00);
    wr(5'h0c, 8'h85);
    rxf(1'b0, 1'b1, 1'b0);
    rd(5'h00, 8'h28, 2'b00);
    rd(5'h10, bd[0], 2'b00);
    wr(5'h00, 8'h00);
    wr(5'h04, 8'h00);
    wr(5'h08, 8'h30);
    rd(5'h04, 8'h11, 2'b00);
    rd(5'h08, 8'hc1, 2'b00);
    wr(5'h0c, 8'ha9);
    for (int k = 0; k < 4; k++) begin
      rxf(k == 2, k != 3, k[0]);
      bd[k] = dat;
      rd(5'h08, 8'hc1 | 8'(((k + 1) % 4) << 4) | (k == 3 ? 8'h08 : 8'h00), 2'b00);
    end
    rd(5'h04, 8'h59, 2'b00);
    rd(5'h00, 8'h21, 2'b00);
    for (int k = 0; k < 4; k++) begin
      rd(5'(16 + 4 * k), bd[k], 2'b00);
    end
    clr();
    round();
    rd(5'h00, 8'h20, 2'b00);
    rd(5'h04, 8'h11, 2'b00);
    rd(5'h08, 8'hc1, 2'b00);
    clr();
    round();
    rd(5'h00, 8'h22, 2'b00);
    rd(5'h04, 8'h33, 2'b00);
    rd(5'h08, 8'hc3, 2'b00);
    // A frozen block must ignore a write, a transmit event and a frame.
    ce <= 1'b0;
    wr(5'h00, 8'hff);
    tx();
    rxf(1'b1, 1'b0, 1'b1);
    ce <= 1'b1;
    rd(5'h00, 8'h22, 2'b00);
    rd(5'h08, 8'hc3, 2'b00);
    repeat (3) cyc(1'b0, 1'b0, addr, wdata, 1'b0, frm, 1'b0);
    end_sim();
  end
endmodule : uart_rx_status_flags_tb
